// File: core/ics_pkg.sv
// Shared constants and types for the I2C slave clock-stretch controller.
package ics_pkg;

  // Bus framing: data bits per byte and the clock that carries the acknowledge.
  localparam logic [3:0] ICS_DATA_BITS = 4'h8;
  localparam logic [3:0] ICS_ACK_CLOCK = 4'h9;

  // Header that opens every 10-bit address (upper five bits of the first byte).
  localparam logic [4:0] ICS_TEN_BIT_HDR = 5'h1e;

  // Field positions.
  localparam int unsigned ICS_RX_STRETCH_POS = 0;  // receive_stretch_enable in serial_control_two
  localparam int unsigned ICS_RW_POS         = 0;  // R/W bit of an address byte

  // Reset values.
  localparam logic       ICS_CKP_RST  = 1'b1;
  localparam logic       ICS_BF_RST   = 1'b0;
  localparam logic       ICS_UA_RST   = 1'b0;
  localparam logic [7:0] ICS_DATA_RST = 8'h00;

  // Phase of the current transfer, one-hot.
  typedef enum logic [5:0] {
    ICS_IDLE    = 6'h01,
    ICS_ADDR1   = 6'h02,
    ICS_ADDR2   = 6'h04,
    ICS_RX_DATA = 6'h08,
    ICS_TX_DATA = 6'h10,
    ICS_IGNORE  = 6'h20
  } ics_phase_t;

  // One-cycle software strobes from the register side.
  typedef struct packed {
    logic ckp_set;     // Software writes 1 to clock_release_bit.
    logic buf_read;    // Software reads serial_data_buffer.
    logic buf_load;    // Software loads serial_data_buffer for transmit.
    logic addr_write;  // Software writes slave_address_register.
    logic ovf_clear;   // Software clears the overflow flag.
  } ics_sw_cmd_t;

  // Status visible to software.
  typedef struct packed {
    logic clock_release_bit;
    logic buffer_full_flag;
    logic address_update_flag;
    logic overflow;
    logic transmit_mode;
    logic scl_held;
  } ics_status_t;

endpackage

// File: core/ics_stretch.sv
// I2C slave clock-stretch controller: watches the bus and holds SCL low on demand.
//
// Notes on behaviour
// - Both 7-bit and 10-bit slave modes stretch automatically in a transmit sequence whose buffer is empty at the ninth fall.
// - Bit 0 of serial_control_two enables stretching at the end of each data receive.
// - In 7-bit receive with stretching on, a set buffer flag at the ninth fall clears the release bit.
// - While the release bit is zero SCL is held low until software sets it again.
// - A buffer read before the ninth fall leaves the release bit set and no stretch occurs.
// - Software may set the release bit at any time; an unread buffer on the next byte is an overflow.
// - In 10-bit receive, address sequences stretch on the address-update flag without touching the release bit.
// - The address-update flag is set after the upper address byte with R/W zero and after a matching low byte.
// - Writing the slave address register clears the address-update flag and releases SCL.
// - 10-bit data receive sequences stretch on the buffer flag exactly as in 7-bit mode.
// - Receive buffer-flag stretching applies only to data sequences, never to address sequences.
// - In 7-bit transmit the ninth fall clears the release bit if the buffer is empty, whatever the enable.
// - A transmit buffer loaded before the ninth fall prevents the stretch; otherwise software must release.
// - In 10-bit transmit the restart header with R/W one sets no update flag and enters buffer-flag transmit.
`timescale 1ns/10ps

module ics_stretch (
  // Clock and reset.
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // I2C pins; the enable is low while the block pulls SCL low.
  input  wire logic                 scl_in,
  output logic                      scl_out,
  output logic                      scl_oe_n,
  input  wire logic                 sda_in,
  // Configuration.
  input  wire logic [7:0]           serial_control_two,
  input  wire logic                 ten_bit_mode,
  input  wire logic [9:0]           slave_address_register,
  // Software strobes.
  input  wire ics_pkg::ics_sw_cmd_t sw_cmd,
  // Status and received byte.
  output ics_pkg::ics_status_t      status,
  output logic [7:0]                serial_data_buffer
);

  // Pin synchronisers and edge history.
  logic scl_s1_q, scl_s2_q, scl_d1_q;
  logic sda_s1_q, sda_s2_q, sda_d1_q;

  // Byte framing.
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic       ten_matched_q;

  // Phase and stretch state.
  ics_pkg::ics_phase_t phase_q;
  logic       ckp_q;
  logic       bf_q;
  logic       ua_q;
  logic       ua_hold_q;
  logic       ovf_q;
  logic [7:0] rx_data_q;

  // Edge and event decode.
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic byte_done, ninth_fall;
  logic [7:0] byte_now;
  logic rx_stretch_en;

  // True when the first byte is the 7-bit own address.
  function automatic logic match7(input logic [7:0] b, input logic [9:0] a);
    match7 = (b[7:1] == a[6:0]);
  endfunction

  // True when the byte is the 10-bit header carrying our upper two address bits.
  function automatic logic match_hdr(input logic [7:0] b, input logic [9:0] a);
    match_hdr = (b[7:3] == ics_pkg::ICS_TEN_BIT_HDR) && (b[2:1] == a[9:8]);
  endfunction

  // Two flops per pin before any logic looks at it; the third flop gives edges.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_d1_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_d1_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_d1_q <= sda_s2_q;
    end
  end

  // Bus events; start and stop are SDA moves while SCL is high.
  assign scl_rise      = scl_s2_q & ~scl_d1_q;
  assign scl_fall      = ~scl_s2_q & scl_d1_q;
  assign start_ev      = scl_s2_q & scl_d1_q & ~sda_s2_q & sda_d1_q;
  assign stop_ev       = scl_s2_q & scl_d1_q & sda_s2_q & ~sda_d1_q;
  assign byte_done     = scl_fall && (bit_cnt_q == ics_pkg::ICS_DATA_BITS);
  assign ninth_fall    = scl_fall && (bit_cnt_q == ics_pkg::ICS_ACK_CLOCK);
  assign byte_now      = shift_q;
  assign rx_stretch_en = serial_control_two[ics_pkg::ICS_RX_STRETCH_POS];

  // Bit counter and shifter; a start or stop always restarts the byte.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_q <= 4'h0;
      shift_q   <= ics_pkg::ICS_DATA_RST;
    end else if (start_ev || stop_ev) begin
      bit_cnt_q <= 4'h0;
    end else if (scl_rise) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (bit_cnt_q < ics_pkg::ICS_DATA_BITS) begin
        shift_q <= {shift_q[6:0], sda_s2_q};
      end
    end else if (ninth_fall) begin
      bit_cnt_q <= 4'h0;
    end
  end

  // Transfer phase; the 10-bit match survives a repeated start for the read header.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q       <= ics_pkg::ICS_IDLE;
      ten_matched_q <= 1'b0;
    end else if (stop_ev) begin
      phase_q       <= ics_pkg::ICS_IDLE;
      ten_matched_q <= 1'b0;
    end else if (start_ev) begin
      phase_q <= ics_pkg::ICS_ADDR1;
    end else if (ninth_fall) begin
      case (phase_q)
        ics_pkg::ICS_ADDR1: begin
          if (!ten_bit_mode) begin
            if (!match7(byte_now, slave_address_register)) begin
              phase_q <= ics_pkg::ICS_IGNORE;
            end else if (byte_now[ics_pkg::ICS_RW_POS]) begin
              phase_q <= ics_pkg::ICS_TX_DATA;
            end else begin
              phase_q <= ics_pkg::ICS_RX_DATA;
            end
          end else if (!match_hdr(byte_now, slave_address_register)) begin
            phase_q <= ics_pkg::ICS_IGNORE;
          end else if (byte_now[ics_pkg::ICS_RW_POS] && ten_matched_q) begin
            phase_q <= ics_pkg::ICS_TX_DATA;
          end else if (byte_now[ics_pkg::ICS_RW_POS]) begin
            phase_q <= ics_pkg::ICS_IGNORE;
          end else begin
            phase_q <= ics_pkg::ICS_ADDR2;
          end
        end
        ics_pkg::ICS_ADDR2: begin
          if (byte_now == slave_address_register[7:0]) begin
            phase_q       <= ics_pkg::ICS_RX_DATA;
            ten_matched_q <= 1'b1;
          end else begin
            phase_q <= ics_pkg::ICS_IGNORE;
          end
        end
        default: begin
          phase_q <= phase_q;
        end
      endcase
    end
  end

  // Buffer-full flag: set by a received data byte or a software load, cleared by a read
  // or by a transmitted byte. A hardware set in the same cycle as a read wins.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bf_q <= ics_pkg::ICS_BF_RST;
    end else if (byte_done && (phase_q == ics_pkg::ICS_RX_DATA)) begin
      bf_q <= 1'b1;
    end else if (sw_cmd.buf_load) begin
      bf_q <= 1'b1;
    end else if (sw_cmd.buf_read) begin
      bf_q <= 1'b0;
    end else if (byte_done && (phase_q == ics_pkg::ICS_TX_DATA)) begin
      bf_q <= 1'b0;
    end
  end

  // Received data byte; the buffer is overwritten even on overflow so the newest byte is kept.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_q <= ics_pkg::ICS_DATA_RST;
    end else if (byte_done && (phase_q == ics_pkg::ICS_RX_DATA)) begin
      rx_data_q <= byte_now;
    end
  end

  // Overflow: a data byte arrives while the previous one is still unread.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_q <= 1'b0;
    end else if (byte_done && (phase_q == ics_pkg::ICS_RX_DATA) && bf_q && !sw_cmd.buf_read) begin
      ovf_q <= 1'b1;
    end else if (sw_cmd.ovf_clear) begin
      ovf_q <= 1'b0;
    end
  end

  // Address-update flag: raised when a matching 10-bit address byte lands so that software can poll it
  // before the ninth fall; the read header of a 10-bit restart never raises it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ua_q <= ics_pkg::ICS_UA_RST;
    end else if (byte_done && ten_bit_mode && (phase_q == ics_pkg::ICS_ADDR1) &&
                 match_hdr(byte_now, slave_address_register) &&
                 !byte_now[ics_pkg::ICS_RW_POS]) begin
      ua_q <= 1'b1;
    end else if (byte_done && (phase_q == ics_pkg::ICS_ADDR2) &&
                 (byte_now == slave_address_register[7:0])) begin
      ua_q <= 1'b1;
    end else if (sw_cmd.addr_write) begin
      ua_q <= 1'b0;
    end
  end

  // Address stretch: begins at the ninth fall if the flag is still up, and ends on the
  // address register write; the release bit is left alone throughout.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ua_hold_q <= 1'b0;
    end else if (ninth_fall && ua_q && !sw_cmd.addr_write) begin
      ua_hold_q <= 1'b1;
    end else if (sw_cmd.addr_write || stop_ev) begin
      ua_hold_q <= 1'b0;
    end
  end

  // Clock-release bit. The automatic clear is decided only at the ninth fall of a data
  // byte (or of the address that opens a transmit); other address bytes never clear it.
  // The hardware clear wins over a software set in the same cycle so a stretch is never lost.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ckp_q <= ics_pkg::ICS_CKP_RST;
    end else if (ninth_fall && (phase_q == ics_pkg::ICS_RX_DATA) && rx_stretch_en && bf_q &&
                 !sw_cmd.buf_read) begin
      ckp_q <= 1'b0;
    end else if (ninth_fall && (phase_q == ics_pkg::ICS_TX_DATA) && !bf_q &&
                 !sw_cmd.buf_load) begin
      ckp_q <= 1'b0;
    end else if (ninth_fall && (phase_q == ics_pkg::ICS_ADDR1) && !ten_bit_mode &&
                 match7(byte_now, slave_address_register) &&
                 byte_now[ics_pkg::ICS_RW_POS] && !bf_q && !sw_cmd.buf_load) begin
      ckp_q <= 1'b0;
    end else if (ninth_fall && (phase_q == ics_pkg::ICS_ADDR1) && ten_bit_mode &&
                 ten_matched_q && match_hdr(byte_now, slave_address_register) &&
                 byte_now[ics_pkg::ICS_RW_POS] && !bf_q && !sw_cmd.buf_load) begin
      ckp_q <= 1'b0;
    end else if (sw_cmd.ckp_set) begin
      ckp_q <= 1'b1;
    end
  end

  // SCL drive: low while the release bit is clear or an address stretch is pending,
  // otherwise released to float high; the master waits on the low line.
  assign scl_out  = 1'b0;
  assign scl_oe_n = ckp_q && !ua_hold_q;

  // Status and data out, all from flip-flops.
  assign status.clock_release_bit   = ckp_q;
  assign status.buffer_full_flag    = bf_q;
  assign status.address_update_flag = ua_q;
  assign status.overflow            = ovf_q;
  assign status.transmit_mode       = (phase_q == ics_pkg::ICS_TX_DATA);
  assign status.scl_held            = !ckp_q || ua_hold_q;
  assign serial_data_buffer         = rx_data_q;

endmodule

// File: tb/ics_stretch_monitor.sv
// Concurrent checks on the ports of the clock-stretch controller.
`timescale 1ns/10ps
module ics_stretch_monitor (
  // Clock and reset.
  input wire logic                 core_clk,
  input wire logic                 rst_n,
  // Observed ports.
  input wire logic                 scl_out,
  input wire logic                 scl_oe_n,
  input wire logic [7:0]           serial_control_two,
  input wire ics_pkg::ics_sw_cmd_t sw_cmd,
  input wire ics_pkg::ics_status_t status
);
  // All checks share the system clock and the reset.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  AST_SCL_OPEN: assert property (scl_out == 1'b0)
    else $error("scl data not low");
  AST_CKP_HOLDS: assert property (!status.clock_release_bit |-> !scl_oe_n)
    else $error("scl free while release bit clear");
  AST_RELEASE: assert property (status.clock_release_bit &&
    !status.address_update_flag |-> scl_oe_n) else $error("scl held without cause");
  AST_CKP_SET: assert property ($rose(status.clock_release_bit) |-> $past(sw_cmd.ckp_set))
    else $error("release bit set by itself");
  AST_HOLD_STAYS: assert property (!status.clock_release_bit &&
    !sw_cmd.ckp_set |=> !scl_oe_n) else $error("stretch ended early");
  AST_RX_ENABLE: assert property ($fell(status.clock_release_bit) &&
    !status.transmit_mode |-> $past(serial_control_two[0])) else $error("rx stretch off");
  AST_ADDR_KEEP: assert property ($fell(status.clock_release_bit)
    |-> !$past(status.address_update_flag)) else $error("release bit cleared in address");
  AST_UA_CLEAR: assert property (sw_cmd.addr_write |=> !status.address_update_flag)
    else $error("update flag kept");
  AST_LOAD: assert property (sw_cmd.buf_load |=> status.buffer_full_flag)
    else $error("load left buffer empty");
  AST_OVF: assert property ($rose(status.overflow) |-> $past(status.buffer_full_flag))
    else $error("overflow without full buffer");

  // Main scenarios reached.
  cover property ($fell(status.clock_release_bit));
  cover property (status.address_update_flag && !scl_oe_n);
  cover property ($rose(status.overflow));
endmodule

bind ics_stretch ics_stretch_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n),
  .scl_out(scl_out), .scl_oe_n(scl_oe_n), .serial_control_two(serial_control_two),
  .sw_cmd(sw_cmd), .status(status));

// File: tb/ics_master.sv
// I2C bus master model that clocks the bus at 360 ns per bit.
`timescale 1ns/10ps
module ics_master (
  // Clock.
  input wire logic core_clk,
  // Bus lines.
  input wire logic scl_line,
  output logic     scl_m,
  output logic     sda_m
);
  // Both lines idle high through their pull-ups.
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Release SCL and wait while the slave stretches it.
  task automatic rise();
    int k;
    scl_m <= 1'b1;
    for (k = 0; k < 4000 && scl_line !== 1'b1; k++) @(posedge core_clk);
    gap(4);
  endtask
  // SDA moves mid-way through the low phase, never near an SCL edge.
  task automatic bit_out(input logic b);
    gap(2);
    sda_m <= b;
    gap(2);
    rise();
    scl_m <= 1'b0;
  endtask
  task automatic start();
    gap(2);
    sda_m <= 1'b1;
    gap(2);
    rise();
    sda_m <= 1'b0;
    gap(4);
    scl_m <= 1'b0;
  endtask
  task automatic stop();
    gap(2);
    sda_m <= 1'b0;
    gap(2);
    rise();
    sda_m <= 1'b1;
    gap(4);
  endtask
  // Eight bits MSB first, then the acknowledge clock with SDA released.
  task automatic put(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_out(1'b1);
  endtask
endmodule

// File: tb/ics_stretch_tb.sv
// Self-checking bench for the clock-stretch controller.
`timescale 1ns/10ps
module ics_stretch_tb;
  localparam ics_pkg::ics_sw_cmd_t c_set = 5'h10, c_rd = 5'h08, c_ld = 5'h04;
  localparam ics_pkg::ics_sw_cmd_t c_aw = 5'h02, c_ro = 5'h09;
  logic                 core_clk, rst_n, scl_m, sda_m, scl_out, scl_oe_n, ten_bit_mode;
  logic [7:0]           sct, buf_q;
  ics_pkg::ics_sw_cmd_t sw_cmd;
  ics_pkg::ics_status_t status;
  int                   err_total, checked;
  // SCL is pulled up and low while either party pulls it.
  wire logic            scl_line = scl_m & scl_oe_n;

  ics_stretch dut (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_line),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_m), .serial_control_two(sct),
    .ten_bit_mode(ten_bit_mode), .slave_address_register(10'h12a), .sw_cmd(sw_cmd),
    .status(status), .serial_data_buffer(buf_q));
  ics_master m (.core_clk(core_clk), .scl_line(scl_line), .scl_m(scl_m), .sda_m(sda_m));

  // System clock, 40 ns.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Release bit, update flag and SCL enable together.
  task automatic hold(input logic ck, input logic ua, input logic oe);
    chk("release bit", 8'(status.clock_release_bit), 8'(ck));
    chk("update flag", 8'(status.address_update_flag), 8'(ua));
    chk("scl enable", 8'(scl_oe_n), 8'(oe));
    chk("scl held", 8'(status.scl_held), 8'(!oe));
  endtask
  // One-cycle strobe, then time for the status to settle.
  task automatic pulse(input ics_pkg::ics_sw_cmd_t c);
    @(posedge core_clk);
    sw_cmd <= c;
    @(posedge core_clk);
    sw_cmd <= '0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic put(input logic [7:0] d);
    m.put(d);
    repeat (8) @(posedge core_clk);
  endtask
  // Software acts on the buffer flag before the ninth falling edge.
  task automatic put_sw(input logic [7:0] d, input logic w, input ics_pkg::ics_sw_cmd_t c);
    fork
      put(d);
      begin
        for (int k = 0; k < 100 && status.buffer_full_flag !== w; k++) @(posedge core_clk);
        pulse(c);
      end
    join
  endtask

  // Main sequence: 7-bit receive, 7-bit transmit, then 10-bit write and read.
  initial begin
    rst_n = 1'b0;
    sct = 8'h01;
    ten_bit_mode = 1'b0;
    sw_cmd = '0;
    err_total = 0;
    checked = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    hold(1'b1, 1'b0, 1'b1);
    m.start();
    put(8'h54);
    hold(1'b1, 1'b0, 1'b1);
    put(8'ha5);
    hold(1'b0, 1'b0, 1'b0);
    chk("data", buf_q, 8'ha5);
    pulse(c_rd);
    pulse(c_set);
    hold(1'b1, 1'b0, 1'b1);
    put_sw(8'h3c, 1'b1, c_rd);
    hold(1'b1, 1'b0, 1'b1);
    sct <= 8'h00;
    put(8'hc3);
    hold(1'b1, 1'b0, 1'b1);
    put(8'h99);
    chk("overflow", 8'(status.overflow), 8'h01);
    pulse(c_ro);
    chk("overflow", 8'(status.overflow), 8'h00);
    m.stop();
    $display("test rx7 done");
    m.start();
    put(8'h55);
    chk("tx mode", 8'(status.transmit_mode), 8'h01);
    hold(1'b0, 1'b0, 1'b0);
    pulse(c_ld);
    pulse(c_set);
    hold(1'b1, 1'b0, 1'b1);
    put_sw(8'hff, 1'b0, c_ld);
    hold(1'b1, 1'b0, 1'b1);
    m.stop();
    $display("test tx7 done");
    ten_bit_mode <= 1'b1;
    sct <= 8'h01;
    m.start();
    put(8'hf2);
    hold(1'b1, 1'b1, 1'b0);
    pulse(c_aw);
    hold(1'b1, 1'b0, 1'b1);
    put(8'h2a);
    hold(1'b1, 1'b1, 1'b0);
    pulse(c_aw);
    put(8'h5a);
    hold(1'b0, 1'b0, 1'b0);
    pulse(c_rd);
    pulse(c_set);
    m.start();
    put(8'hf3);
    chk("tx mode", 8'(status.transmit_mode), 8'h01);
    hold(1'b0, 1'b0, 1'b0);
    pulse(c_ld);
    pulse(c_set);
    hold(1'b1, 1'b0, 1'b1);
    m.stop();
    $display("test ten bit done");
    end_sim();
  end
  // The whole run needs some 1100 cycles; a hang is cut off well beyond.
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    end_sim();
  end
endmodule
